// File: pwsc_bus_master.sv
// two-wire bus master model facing the pot control slave
`default_nettype none
module pwsc_bus_master (
    // clock
    input wire logic clk_in,
    // two-wire bus
    input wire logic sda_in,
    output logic scl_out,
    output logic sda_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        scl_out = 1'b1;
        sda_out = 1'b1;
    end
    task automatic quarter();
        repeat (4) @(posedge clk_in);
    endtask : quarter
    // data moves only while scl is low, so no false start or stop
    task automatic put_bit(input logic b, output logic got);
        quarter();
        sda_out <= b;
        quarter();
        scl_out <= 1'b1;
        quarter();
        quarter();
        got = sda_in;
        scl_out <= 1'b0;
    endtask : put_bit
    task automatic start_cond();
        quarter();
        sda_out <= 1'b1;
        quarter();
        scl_out <= 1'b1;
        quarter();
        sda_out <= 1'b0;
        quarter();
        scl_out <= 1'b0;
    endtask : start_cond
    task automatic stop_cond();
        quarter();
        sda_out <= 1'b0;
        quarter();
        scl_out <= 1'b1;
        quarter();
        sda_out <= 1'b1;
        quarter();
    endtask : stop_cond
    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic g;
        for (int i = 7; i >= 0; i--) put_bit(b[i], g);
        put_bit(1'b1, g);
        ack = !g;
    endtask : send_byte
    task automatic recv_byte(output logic [7:0] v);
        logic g;
        for (int i = 0; i < 8; i++) begin
            put_bit(1'b1, g);
            v = {v[6:0], g};
        end
        put_bit(1'b1, g);
    endtask : recv_byte
endmodule : pwsc_bus_master
`default_nettype wire

// File: pwsc_persist_store.sv
// persistent wiper store and pot write lock
`default_nettype none
module pwsc_persist_store (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // write ports
    input wire logic write_en_in,
    input wire logic [1:0] sel_in,
    input wire logic [7:0] data_in,
    input wire logic lock_write_en_in,
    input wire logic lock_in,
    // stored contents
    output pwsc_pkg::pwsc_store_s store_out
);
    pwsc_pkg::pwsc_store_s s;
    pwsc_pkg::pwsc_store_s next_s;

    always_comb begin
        next_s = s;
        if (write_en_in && sel_in != pwsc_pkg::POT_RSVD) begin
            next_s.wiper_data[sel_in] = data_in; // RULE24
        end
        if (lock_write_en_in) begin
            next_s.lock = lock_in;
        end
    end

    // power loss is not modelled: reset stands for the shipped contents
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s <= '{wiper_data: {3{pwsc_pkg::STORE_RESET}}, lock: 1'b0}; // RULE8
        end else begin
            s <= next_s;
        end
    end

    assign store_out = s;
endmodule : pwsc_persist_store
`default_nettype wire

// File: pwsc_pkg.sv
// package: constants and types for the pot wiper serial control block
`default_nettype none
// How it works
// RULE1 - pot write address 10101110 is acknowledged
// RULE2 - instruction picks pot and persist select
// RULE3 - codes 00,01,10 pick 64,100,256-tap pots
// RULE4 - pot select 11 is not acknowledged
// RULE5 - data loads on eighth data rising edge
// RULE6 - oversized data saturates at highest tap
// RULE7 - 64/256-tap pots use data as tap
// RULE8 - persistent store starts at 00h
// RULE9 - dummy write selects pot for reading
// RULE10 - read address returns selected wiper byte
// RULE11 - unused top readback bits read as zero
// RULE12 - volatile control bits power up zero
// RULE13 - control bit layout, reserved bits zero
// RULE14 - no write enable: abort, no data ack
// RULE15 - writing 02h sets write enable latch
// RULE16 - latch write leaves device ready at stop
// RULE17 - other control bits need register unlock
// RULE18 - unlock sets only with write enable
// RULE19 - unlock clears after completed register write
// RULE20 - pot write lock rejects pot writes
// RULE21 - write protect pin blocks persistent writes
// RULE22 - monitor flag sets only while output high
// RULE23 - monitor flag clears when output low
// RULE24 - persist select writes wiper and store
// RULE25 - address 111 pots, 010 control register
// RULE26 - busy after persistent write, address unacked
// RULE27 - wipers load from store at power-up
// RULE28 - 100-tap translation in its own module
package pwsc_pkg;
    localparam logic [3:0] DEV_TYPE = 4'ha;
    localparam logic [2:0] SEL_POTS = 3'h7;
    localparam logic [2:0] SEL_CTRL = 3'h2;
    localparam logic [1:0] POT0 = 2'h0;
    localparam logic [1:0] POT1 = 2'h1;
    localparam logic [1:0] POT2 = 2'h2;
    localparam logic [1:0] POT_RSVD = 2'h3;
    localparam int PERSIST_BIT = 7;
    localparam logic [7:0] POT0_MAX = 8'h3f;
    localparam logic [7:0] POT1_MAX_TAP = 8'h63;
    localparam logic [7:0] CTRL_ADDR_BYTE = 8'hff;
    localparam logic [7:0] STORE_RESET = 8'h00;
    localparam logic [7:0] WEL_SET_VALUE = 8'h02;
    localparam logic [7:0] WEL_CLEAR_VALUE = 8'h00;
    localparam int CS_MON2 = 6;
    localparam int CS_MON3 = 5;
    localparam int CS_LOCK = 3;
    localparam int CS_UNLOCK = 2;
    localparam int CS_WEL = 1;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam int CLK_HZ = 40_000_000;
    localparam int PERSIST_CYCLE_MS = 5;
    localparam int PERSIST_CYCLE_CYCLES = CLK_HZ / 1000 * PERSIST_CYCLE_MS;
    localparam int BUSY_W = 24;

    typedef enum logic [3:0] {
        ST_INIT = 4'hf,
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_ADDR_ACK = 4'h3,
        ST_INSTR = 4'h2,
        ST_INSTR_ACK = 4'h6,
        ST_DATA = 4'h7,
        ST_DATA_ACK = 4'h5,
        ST_RD_BYTE = 4'h4,
        ST_IGNORE = 4'hc
    } pwsc_state_e;

    typedef struct packed {
        logic [2:0][7:0] wiper_data;
        logic lock;
    } pwsc_store_s;

    typedef struct packed {
        pwsc_state_e st;
        logic scl_q;
        logic sda_q;
        logic [3:0] bitcnt;
        logic [7:0] shreg;
        logic acked;
        logic ack_driven;
        logic rw;
        logic to_ctrl;
        logic [1:0] sel;
        logic persist;
        logic got_data;
        logic pend_pot;
        logic pend_ctrl;
        logic [7:0] pend_data;
        logic write_enable_latch;
        logic unlock;
        logic mon2;
        logic mon3;
        logic [5:0] w0;
        logic [6:0] w1;
        logic [7:0] w2;
        logic store_we;
        logic lock_we;
        logic lock_d;
        logic [BUSY_W-1:0] busy_cnt;
        logic busy_q;
        logic [7:0] csr_q;
        logic sda_oe;
    } pwsc_regs_s;

    localparam pwsc_regs_s REGS_RESET = '{st: ST_INIT, scl_q: 1'b1, sda_q: 1'b1, default: '0};
endpackage : pwsc_pkg
`default_nettype wire

// File: pwsc_tap100_map.sv
// data byte to tap translation for the 100-tap pot
`default_nettype none
module pwsc_tap100_map (
    // translation
    input wire logic [7:0] data_in,
    output logic [6:0] tap_out
);
    // straight mapping with saturation; swap in the real table here
    always_comb begin
        if (data_in > pwsc_pkg::POT1_MAX_TAP) begin // RULE6
            tap_out = pwsc_pkg::POT1_MAX_TAP[6:0];
        end else begin
            tap_out = data_in[6:0]; // RULE28
        end
    end
endmodule : pwsc_tap100_map
`default_nettype wire

// File: pwsc_top.sv
// two-wire slave front end for the triple pot wiper control
`default_nettype none
module pwsc_top #(
    parameter int unsigned PERSIST_CYCLES = pwsc_pkg::PERSIST_CYCLE_CYCLES
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    // two-wire bus
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    // protection and monitors
    input wire logic write_protect_in,
    input wire logic mon2_reset_out_in,
    input wire logic mon3_reset_out_in,
    // wiper positions and status
    output logic [5:0] wiper0_tap_out,
    output logic [6:0] wiper1_tap_out,
    output logic [7:0] wiper2_tap_out,
    output logic [7:0] control_status_out,
    output logic busy_out
);
    if (PERSIST_CYCLES == 0 || PERSIST_CYCLES >= (1 << pwsc_pkg::BUSY_W)) begin : g_bad_cycles
        $error("PERSIST_CYCLES out of range");
    end

    localparam logic [pwsc_pkg::BUSY_W-1:0] BUSY_LOAD = PERSIST_CYCLES[pwsc_pkg::BUSY_W-1:0];

    // -------------------------------------------------------------
    // reset release
    // -------------------------------------------------------------
    logic [1:0] rst_sync;
    logic rst_n;

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // -------------------------------------------------------------
    // decode helpers
    // -------------------------------------------------------------
    function automatic logic [7:0] csr_value(input logic write_enable_latch, input logic unlock, input logic lock,
                                             input logic mon2, input logic mon3);
        logic [7:0] v;
        v = 8'h00; // RULE13
        v[pwsc_pkg::CS_WEL] = write_enable_latch;
        v[pwsc_pkg::CS_UNLOCK] = unlock;
        v[pwsc_pkg::CS_LOCK] = lock;
        v[pwsc_pkg::CS_MON2] = mon2;
        v[pwsc_pkg::CS_MON3] = mon3;
        return v;
    endfunction : csr_value

    function automatic logic [5:0] sat64(input logic [7:0] d);
        return (d > pwsc_pkg::POT0_MAX) ? pwsc_pkg::POT0_MAX[5:0] : d[5:0]; // RULE6 RULE7
    endfunction : sat64

    // -------------------------------------------------------------
    // state and submodules
    // -------------------------------------------------------------
    pwsc_pkg::pwsc_regs_s s;
    pwsc_pkg::pwsc_regs_s next_s;
    pwsc_pkg::pwsc_store_s store;
    logic [7:0] byte_in;
    logic [7:0] lut_in;
    logic [6:0] lut_tap;
    logic [7:0] rd_val;
    logic scl_r;
    logic scl_f;
    logic start_c;
    logic stop_c;
    logic lock;

    assign lock = store.lock;
    assign byte_in = {s.shreg[6:0], sda_in};
    assign lut_in = (s.st == pwsc_pkg::ST_INIT) ? store.wiper_data[1] : byte_in;
    assign scl_r = scl_in & ~s.scl_q;
    assign scl_f = ~scl_in & s.scl_q;
    assign start_c = s.scl_q & scl_in & s.sda_q & ~sda_in;
    assign stop_c = s.scl_q & scl_in & ~s.sda_q & sda_in;

    pwsc_tap100_map u_map (
        .data_in(lut_in),
        .tap_out(lut_tap)
    );

    pwsc_persist_store u_store (
        .clk_in(sys_clk_in),
        .rst_n_in(rst_n),
        .write_en_in(s.store_we),
        .sel_in(s.sel),
        .data_in(s.pend_data),
        .lock_write_en_in(s.lock_we),
        .lock_in(s.lock_d),
        .store_out(store)
    );

    // readback: unused upper bits of the narrow pots read as zero
    always_comb begin
        if (s.to_ctrl) begin
            rd_val = csr_value(s.write_enable_latch, s.unlock, lock, s.mon2, s.mon3);
        end else begin
            unique case (s.sel)
                pwsc_pkg::POT0: rd_val = {2'h0, s.w0}; // RULE11
                pwsc_pkg::POT1: rd_val = {1'b0, s.w1}; // RULE11
                pwsc_pkg::POT2: rd_val = s.w2;
                pwsc_pkg::POT_RSVD: rd_val = 8'h00;
            endcase
        end
    end

    // -------------------------------------------------------------
    // next state
    // -------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.scl_q = scl_in;
        next_s.sda_q = sda_in;
        next_s.store_we = 1'b0;
        next_s.lock_we = 1'b0;
        if (s.busy_cnt != '0) begin
            next_s.busy_cnt = s.busy_cnt - 1'b1;
        end
        next_s.mon2 = s.mon2 & mon2_reset_out_in; // RULE23
        next_s.mon3 = s.mon3 & mon3_reset_out_in; // RULE23
        unique case (s.st)
            pwsc_pkg::ST_INIT: begin
                next_s.w0 = sat64(store.wiper_data[0]); // RULE27
                next_s.w1 = lut_tap;
                next_s.w2 = store.wiper_data[2];
                next_s.st = pwsc_pkg::ST_IDLE;
            end
            pwsc_pkg::ST_IDLE, pwsc_pkg::ST_IGNORE: begin
            end
            pwsc_pkg::ST_ADDR, pwsc_pkg::ST_INSTR, pwsc_pkg::ST_DATA: begin
                if (scl_r) begin
                    next_s.shreg = byte_in;
                    next_s.bitcnt = s.bitcnt + 4'h1;
                    next_s.ack_driven = 1'b0;
                end
                if (scl_r && s.bitcnt == pwsc_pkg::BITS_PER_BYTE - 4'h1) begin
                    if (s.st == pwsc_pkg::ST_ADDR) begin
                        next_s.st = pwsc_pkg::ST_ADDR_ACK;
                        next_s.rw = byte_in[0];
                        next_s.to_ctrl = byte_in[3:1] == pwsc_pkg::SEL_CTRL; // RULE25
                        next_s.acked = byte_in[7:4] == pwsc_pkg::DEV_TYPE && s.busy_cnt == '0 // RULE1 RULE26
                            && (byte_in[3:1] == pwsc_pkg::SEL_POTS || byte_in[3:1] == pwsc_pkg::SEL_CTRL);
                    end else if (s.st == pwsc_pkg::ST_INSTR) begin
                        next_s.st = pwsc_pkg::ST_INSTR_ACK;
                        if (s.to_ctrl) begin
                            next_s.acked = byte_in == pwsc_pkg::CTRL_ADDR_BYTE;
                        end else begin
                            next_s.sel = byte_in[1:0]; // RULE2 RULE9
                            next_s.persist = byte_in[pwsc_pkg::PERSIST_BIT];
                            next_s.acked = byte_in[1:0] != pwsc_pkg::POT_RSVD; // RULE4
                        end
                    end else begin
                        next_s.st = pwsc_pkg::ST_DATA_ACK;
                        next_s.got_data = 1'b1;
                        if (s.got_data) begin
                            // a second data byte cancels the pending store or control write; the wiper keeps the first byte
                            next_s.acked = 1'b0;
                            next_s.pend_pot = 1'b0;
                            next_s.pend_ctrl = 1'b0;
                        end else if (s.to_ctrl) begin
                            next_s.acked = s.write_enable_latch || byte_in == pwsc_pkg::WEL_SET_VALUE // RULE14
                                || byte_in == pwsc_pkg::WEL_CLEAR_VALUE;
                            next_s.pend_ctrl = next_s.acked;
                            next_s.pend_data = byte_in;
                        end else begin
                            next_s.acked = s.write_enable_latch && !lock // RULE14 RULE20
                                && !(s.persist && write_protect_in); // RULE21
                            if (next_s.acked) begin
                                next_s.pend_pot = s.persist; // RULE24
                                next_s.pend_data = byte_in;
                                unique case (s.sel) // RULE3 RULE5
                                    pwsc_pkg::POT0: next_s.w0 = sat64(byte_in);
                                    pwsc_pkg::POT1: next_s.w1 = lut_tap;
                                    pwsc_pkg::POT2: next_s.w2 = byte_in; // RULE7
                                    pwsc_pkg::POT_RSVD: next_s.acked = 1'b0;
                                endcase
                            end
                        end
                    end
                end
            end
            pwsc_pkg::ST_ADDR_ACK, pwsc_pkg::ST_INSTR_ACK, pwsc_pkg::ST_DATA_ACK: begin
                // first falling edge drives the acknowledge, second releases it
                if (scl_f && !s.ack_driven) begin
                    next_s.sda_oe = s.acked;
                    next_s.ack_driven = 1'b1;
                end else if (scl_f) begin
                    next_s.sda_oe = 1'b0;
                    next_s.bitcnt = 4'h0;
                    if (!s.acked) begin
                        next_s.st = pwsc_pkg::ST_IGNORE;
                    end else if (s.st == pwsc_pkg::ST_ADDR_ACK && s.rw) begin
                        next_s.st = pwsc_pkg::ST_RD_BYTE; // RULE10
                        next_s.sda_oe = ~rd_val[7];
                        next_s.shreg = {rd_val[6:0], 1'b0};
                        next_s.bitcnt = 4'h1;
                    end else if (s.st == pwsc_pkg::ST_ADDR_ACK) begin
                        next_s.st = pwsc_pkg::ST_INSTR;
                    end else begin
                        next_s.st = pwsc_pkg::ST_DATA;
                    end
                end
            end
            pwsc_pkg::ST_RD_BYTE: begin
                // one byte per read; the master's acknowledge is not looked at
                if (scl_f && s.bitcnt == pwsc_pkg::BITS_PER_BYTE) begin
                    next_s.sda_oe = 1'b0;
                    next_s.st = pwsc_pkg::ST_IGNORE;
                end else if (scl_f) begin
                    next_s.sda_oe = ~s.shreg[7];
                    next_s.shreg = {s.shreg[6:0], 1'b0};
                    next_s.bitcnt = s.bitcnt + 4'h1;
                end
            end
            default: next_s.st = pwsc_pkg::ST_IDLE;
        endcase
        if (start_c && s.st != pwsc_pkg::ST_INIT) begin
            next_s.st = pwsc_pkg::ST_ADDR;
            next_s.bitcnt = 4'h0;
            next_s.sda_oe = 1'b0;
            next_s.got_data = 1'b0;
            // a restart drops a half-built write; a later stop must not store it
            next_s.pend_pot = 1'b0;
            next_s.pend_ctrl = 1'b0;
        end
        if (stop_c && s.st != pwsc_pkg::ST_INIT) begin
            next_s.st = pwsc_pkg::ST_IDLE;
            next_s.sda_oe = 1'b0;
            next_s.pend_pot = 1'b0;
            next_s.pend_ctrl = 1'b0;
            if (s.pend_pot) begin
                next_s.store_we = 1'b1; // RULE24
                next_s.busy_cnt = BUSY_LOAD; // RULE26
            end
            if (s.pend_ctrl) begin
                next_s.write_enable_latch = s.pend_data[pwsc_pkg::CS_WEL]; // RULE15 RULE16
                if (s.write_enable_latch && s.unlock) begin // RULE17
                    next_s.mon2 = s.pend_data[pwsc_pkg::CS_MON2] & mon2_reset_out_in; // RULE22
                    next_s.mon3 = s.pend_data[pwsc_pkg::CS_MON3] & mon3_reset_out_in; // RULE22
                    if (!s.pend_data[pwsc_pkg::CS_UNLOCK]) begin
                        next_s.unlock = 1'b0; // RULE19
                        if (!write_protect_in) begin
                            next_s.lock_we = 1'b1;
                            next_s.lock_d = s.pend_data[pwsc_pkg::CS_LOCK];
                            next_s.busy_cnt = BUSY_LOAD;
                        end
                    end
                end else if (s.write_enable_latch && s.pend_data[pwsc_pkg::CS_UNLOCK]) begin
                    next_s.unlock = 1'b1; // RULE18
                end
            end
        end
        next_s.busy_q = next_s.busy_cnt != '0;
        next_s.csr_q = csr_value(next_s.write_enable_latch, next_s.unlock, lock, next_s.mon2, next_s.mon3);
    end

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            s <= pwsc_pkg::REGS_RESET; // RULE12
        end else begin
            s <= next_s;
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe_out = s.sda_oe;
    assign wiper0_tap_out = s.w0;
    assign wiper1_tap_out = s.w1;
    assign wiper2_tap_out = s.w2;
    assign control_status_out = s.csr_q;
    assign busy_out = s.busy_q;

    // -------------------------------------------------------------
    // checks
    // -------------------------------------------------------------
    a_busy_no_ack: assert property (@(posedge sys_clk_in) disable iff (!rst_n) // RULE26
        s.busy_q |-> !s.sda_oe) else $error("bus driven while busy");

    a_rsvd_pot_nack: assert property (@(posedge sys_clk_in) disable iff (!rst_n) // RULE4
        (s.st == pwsc_pkg::ST_INSTR_ACK && !s.to_ctrl && s.sel == pwsc_pkg::POT_RSVD) |-> !s.sda_oe)
        else $error("reserved pot select acknowledged");

    a_wiper_needs_wel: assert property (@(posedge sys_clk_in) disable iff (!rst_n) // RULE14
        ($changed(s.w2) && $past(s.st) != pwsc_pkg::ST_INIT) |-> $past(s.write_enable_latch))
        else $error("wiper moved without write enable");

    a_wiper_lock: assert property (@(posedge sys_clk_in) disable iff (!rst_n) // RULE20
        ($changed(s.w0) && $past(s.st) != pwsc_pkg::ST_INIT) |-> !$past(lock))
        else $error("wiper moved while locked");

    a_unlock_needs_wel: assert property (@(posedge sys_clk_in) disable iff (!rst_n) // RULE18
        $rose(s.unlock) |-> $past(s.write_enable_latch)) else $error("unlock set without write enable");

    a_mon2_clear: assert property (@(posedge sys_clk_in) disable iff (!rst_n) // RULE23
        !mon2_reset_out_in |=> !s.mon2) else $error("monitor flag held while output low");

    a_mon3_set: assert property (@(posedge sys_clk_in) disable iff (!rst_n) // RULE22
        $rose(s.mon3) |-> $past(mon3_reset_out_in)) else $error("monitor flag set while output low");

    a_persist_busy: assert property (@(posedge sys_clk_in) disable iff (!rst_n) // RULE24
        s.store_we |-> s.busy_q ##1 s.busy_q) else $error("persistent write without busy");

    a_wp_block: assert property (@(posedge sys_clk_in) disable iff (!rst_n) // RULE21
        $rose(s.pend_pot) |-> !$past(write_protect_in)) else $error("persistent write under protect");

    a_data_edge: assert property (@(posedge sys_clk_in) disable iff (!rst_n) // RULE5
        ($changed(s.w2) && $past(s.st) == pwsc_pkg::ST_DATA) |-> s.st == pwsc_pkg::ST_DATA_ACK)
        else $error("wiper loaded outside data byte end");

    // power-up load, register protection, busy, read length and monitor flags
    a_init_load: assert property (@(posedge sys_clk_in) disable iff (!rst_n) // RULE27
        s.st == pwsc_pkg::ST_INIT |=> s.w2 == $past(store.wiper_data[2])) else $error("wiper not loaded");

    a_lock_needs_unlock: assert property (@(posedge sys_clk_in) disable iff (!rst_n) // RULE17
        s.lock_we |-> $past(s.unlock) && $past(s.write_enable_latch)) else $error("lock written while locked out");

    a_unlock_clears: assert property (@(posedge sys_clk_in) disable iff (!rst_n) // RULE19
        s.lock_we |-> !s.unlock) else $error("unlock kept after register write");

    a_lock_busy: assert property (@(posedge sys_clk_in) disable iff (!rst_n) // RULE26
        s.lock_we |-> s.busy_q) else $error("lock write without busy");

    a_wel_no_busy: assert property (@(posedge sys_clk_in) disable iff (!rst_n) // RULE16
        $rose(s.write_enable_latch) |-> !s.busy_q) else $error("latch write started busy");

    a_rd_one_byte: assert property (@(posedge sys_clk_in) disable iff (!rst_n) // RULE10
        (s.st == pwsc_pkg::ST_RD_BYTE && scl_f && s.bitcnt == pwsc_pkg::BITS_PER_BYTE) |=> !s.sda_oe)
        else $error("read drove past one byte");

    a_mon2_set: assert property (@(posedge sys_clk_in) disable iff (!rst_n) // RULE22
        $rose(s.mon2) |-> $past(mon2_reset_out_in)) else $error("mon2 flag set while output low");

    a_mon3_clear: assert property (@(posedge sys_clk_in) disable iff (!rst_n) // RULE23
        !mon3_reset_out_in |=> !s.mon3) else $error("mon3 flag held while output low");
endmodule : pwsc_top
`default_nettype wire

// File: tb_pwsc_top.sv
// self-checking bench for the pot wiper serial control block
`default_nettype none
module tb_pwsc_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned PCYC = 400;
    localparam logic [7:0] ROWS [0:5][0:2] = '{'{8'h01, 8'h30, 8'h30}, '{8'h01, 8'hc8, 8'h63},
        '{8'h02, 8'ha5, 8'ha5}, '{8'h02, 8'hff, 8'hff}, '{8'h00, 8'h15, 8'h15}, '{8'h00, 8'h7f, 8'h3f}};
    logic sys_clk, resetn, write_protect, mon2, mon3, sda_out, sda_oe, busy, scl, sda_m, a, ai, ad;
    logic [5:0] w0;
    logic [6:0] w1;
    logic [7:0] w2, cs, v;
    int errors = 0;
    int compares = 0;
    // open drain wire with pull-up
    wire logic sda = sda_m & (sda_oe ? sda_out : 1'b1);
    pwsc_bus_master u_pwsc_bus_master (.clk_in(sys_clk), .sda_in(sda), .scl_out(scl), .sda_out(sda_m));
    pwsc_top #(.PERSIST_CYCLES(PCYC)) u_pwsc_top (.sys_clk_in(sys_clk), .resetn_in(resetn), .scl_in(scl),
        .sda_in(sda), .sda_out(sda_out), .sda_oe_out(sda_oe), .write_protect_in(write_protect),
        .mon2_reset_out_in(mon2), .mon3_reset_out_in(mon3), .wiper0_tap_out(w0), .wiper1_tap_out(w1),
        .wiper2_tap_out(w2), .control_status_out(cs), .busy_out(busy));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic end_sim();
        if (errors == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    function automatic logic [7:0] tap(input logic [1:0] s);
        return (s == 2'h0) ? {2'h0, w0} : (s == 2'h1) ? {1'b0, w1} : w2;
    endfunction : tap
    task automatic pot_wr(input logic [1:0] s, input logic p, input logic [7:0] d);
        u_pwsc_bus_master.start_cond();
        u_pwsc_bus_master.send_byte(8'hae, a);
        chk({7'h0, a}, 8'h01);
        u_pwsc_bus_master.send_byte({p, 5'h00, s}, ai);
        u_pwsc_bus_master.send_byte(d, ad);
        u_pwsc_bus_master.stop_cond();
    endtask : pot_wr
    task automatic ctrl_wr(input logic [7:0] d);
        u_pwsc_bus_master.start_cond();
        u_pwsc_bus_master.send_byte(8'ha4, a);
        u_pwsc_bus_master.send_byte(8'hff, a);
        u_pwsc_bus_master.send_byte(d, a);
        u_pwsc_bus_master.stop_cond();
    endtask : ctrl_wr
    task automatic pot_rd(input logic [1:0] s, input logic c);
        u_pwsc_bus_master.start_cond();
        u_pwsc_bus_master.send_byte(c ? 8'ha4 : 8'hae, a);
        u_pwsc_bus_master.send_byte(c ? 8'hff : {6'h00, s}, ai);
        chk({7'h0, ai}, 8'h01);
        u_pwsc_bus_master.start_cond();
        u_pwsc_bus_master.send_byte(c ? 8'ha5 : 8'haf, a);
        chk({7'h0, a}, 8'h01);
        u_pwsc_bus_master.recv_byte(v);
        u_pwsc_bus_master.stop_cond();
    endtask : pot_rd
    // bounded wait for the store cycle to finish
    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 1000) begin
            @(posedge sys_clk);
            n++;
        end
        chk({7'h0, busy}, 8'h00);
    endtask : wait_idle
    // ----------------------------------------
    // clock, watchdog and sequence
    // ----------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (100000) @(posedge sys_clk);
        errors++;
        end_sim();
    end
    initial begin
        resetn = 1'b0;
        write_protect = 1'b0;
        mon2 = 1'b0;
        mon3 = 1'b0;
        repeat (8) @(posedge sys_clk);
        resetn <= 1'b1;
        repeat (6) @(posedge sys_clk);
        chk(w2, 8'h00);
        chk(cs, 8'h00);
        chk(tap(2'h0) | tap(2'h1), 8'h00);
        pot_wr(2'h2, 1'b0, 8'h11);
        chk({ai, ad, w2[5:0]}, 8'h80);
        ctrl_wr(8'h02);
        chk(cs, 8'h02);
        chk({7'h0, busy}, 8'h00);
        for (int r = 0; r < 6; r++) begin
            pot_wr(ROWS[r][0][1:0], 1'b0, ROWS[r][1]);
            chk({ai, ad, 6'h00}, 8'hc0);
            chk(tap(ROWS[r][0][1:0]), ROWS[r][2]);
            pot_rd(ROWS[r][0][1:0], 1'b0);
            chk(v, ROWS[r][2]);
        end
        pot_wr(2'h3, 1'b0, 8'h01);
        chk({7'h0, ai}, 8'h00);
        pot_wr(2'h2, 1'b1, 8'h3c);
        chk(w2, 8'h3c);
        chk({7'h0, busy}, 8'h01);
        u_pwsc_bus_master.start_cond();
        u_pwsc_bus_master.send_byte(8'hae, a);
        u_pwsc_bus_master.stop_cond();
        chk({7'h0, a}, 8'h00);
        wait_idle();
        write_protect <= 1'b1;
        pot_wr(2'h0, 1'b1, 8'h2a);
        chk({ad, 1'b0, w0}, 8'h3f);
        pot_wr(2'h0, 1'b0, 8'h2a);
        chk({ad, 1'b0, w0}, 8'haa);
        write_protect <= 1'b0;
        ctrl_wr(8'h06);
        chk(cs, 8'h06);
        mon2 <= 1'b1;
        ctrl_wr(8'h6a);
        chk(cs, 8'h4a);
        wait_idle();
        pot_wr(2'h2, 1'b0, 8'h77);
        chk({ad, w2[6:0]}, 8'h3c);
        mon2 <= 1'b0;
        repeat (4) @(posedge sys_clk);
        chk(cs, 8'h0a);
        ctrl_wr(8'h00);
        chk(cs, 8'h08);
        ctrl_wr(8'h06);
        chk({a, cs[6:0]}, 8'h08);
        ctrl_wr(8'h02);
        ctrl_wr(8'h06);
        pot_rd(2'h0, 1'b1);
        chk(v, 8'h0e);
        mon3 <= 1'b1;
        ctrl_wr(8'h20);
        chk(cs, 8'h20);
        chk({7'h0, busy}, 8'h01);
        end_sim();
    end
endmodule : tb_pwsc_top
`default_nettype wire
